// ### hdl/tpef_pkg.sv
// package: constants and types for timer event flag logic
// Behaviour
// - free-running counter sets overflow flag on 0xFFFF to 0x0000 transition.
// - centre mode off: overflow flag set when counter wraps modulo to zero.
// - centre mode on: overflow flag set when counter reverses at modulo.
// - capture channel, centre mode off: two-bit edge select chooses none, rising, falling, either edge; centre mode on flags on match.
// - compare channel: flag set whenever the running counter equals 16-bit compare value.
// - edge PWM channel: flag set at match ending active duty.
// - centre PWM channel: flag set on both matches each period.
// - one overflow source and one per channel, each with own enable.
// - enabled request held as level while its flag is one.
// - interrupt request outputs are active high.
// - flags set regardless of enable and stay readable for polling.
// - flag clears only by write zero following a read while set.
// - event between read and write restarts sequence; flag stays set.
// - any reset clears main control: clock stopped, overflow enable cleared.
// - centre mode counts up to modulo then down to zero.
`default_nettype none
package tpef_pkg;
  localparam int CNT_W = 16;
  localparam int NUM_CH = 2;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_FULL = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

  // channel modes
  typedef enum logic [1:0] {
    TPEF_CH_CAPTURE,
    TPEF_CH_COMPARE,
    TPEF_CH_EDGE_PWM
  } tpef_ch_mode_t;

  // edge-select field encodings
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_ANY = 2'h3;

  // per-channel configuration bundle
  typedef struct packed {
    tpef_ch_mode_t    mode;
    logic             edge_level_select_hi;
    logic             edge_level_select_lo;
    logic             channel_irq_enable;
    logic [CNT_W-1:0] value;
  } tpef_ch_cfg_t;

  // software access strobes toward one flag
  typedef struct packed {
    logic rd;
    logic wr;
    logic wdata;
  } tpef_sw_t;
endpackage
`default_nettype wire

// ### hdl/tpef_flag.sv
// module: one sticky event flag with read-then-write-zero clear
`default_nettype none
module tpef_flag (
  input  wire logic           clk,
  input  wire logic           rst,
  input  wire logic           event_pulse,
  input  wire tpef_pkg::tpef_sw_t sw,
  output logic                flag
);
  logic flag_reg;
  logic armed_reg;
  logic flag_next;
  logic armed_next;
  logic clr_ok;

  // clear only when armed by a read that saw one
  // read then write zero
  assign clr_ok = armed_reg & sw.wr & ~sw.wdata & ~event_pulse;
  assign flag_next = event_pulse | (flag_reg & ~clr_ok);
  assign armed_next = event_pulse ? 1'b0 :
                      (sw.rd & flag_reg) ? 1'b1 :
                      sw.wr ? 1'b0 : armed_reg;
  assign flag = flag_reg;

  // state update
  always_ff @(posedge clk) begin
    if (rst) begin
      flag_reg  <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      flag_reg  <= flag_next;
      armed_reg <= armed_next;
    end
  end
endmodule
`default_nettype wire

// ### hdl/tpef_counter.sv
// module: timer counter, free, modulo or up/down centre-aligned
`default_nettype none
module tpef_counter (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       run,
  input  wire logic                       center_align_select,
  input  wire logic [tpef_pkg::CNT_W-1:0] modulo,
  output logic [tpef_pkg::CNT_W-1:0]      count,
  output logic                            counting_down,
  output logic                            ovf_event
);
  logic [tpef_pkg::CNT_W-1:0] cnt_reg;
  logic [tpef_pkg::CNT_W-1:0] cnt_next;
  logic                       down_reg;
  logic                       down_next;
  logic [tpef_pkg::CNT_W-1:0] term;
  logic                       at_term;
  logic                       at_zero;

  // modulo zero means full range
  assign term = (modulo == tpef_pkg::CNT_ZERO) ? tpef_pkg::CNT_FULL : modulo;
  assign at_term = (cnt_reg == term);
  assign at_zero = (cnt_reg == tpef_pkg::CNT_ZERO);

  // up to modulo then down to zero
  assign down_next = !center_align_select ? 1'b0 :
                     (!down_reg && at_term) ? 1'b1 :
                     (down_reg && at_zero) ? 1'b0 : down_reg;
  assign cnt_next = !run ? cnt_reg :
                    !center_align_select ? (at_term ? tpef_pkg::CNT_ZERO : cnt_reg + tpef_pkg::CNT_ONE) :
                    down_next ? cnt_reg - tpef_pkg::CNT_ONE : cnt_reg + tpef_pkg::CNT_ONE;

  assign ovf_event = run & at_term & (!center_align_select | !down_reg);
  assign count = cnt_reg;
  assign counting_down = down_reg;

  // counter state
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg  <= tpef_pkg::CNT_ZERO;
      down_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      down_reg <= run ? down_next : down_reg;
    end
  end
endmodule
`default_nettype wire

// ### hdl/tpef_top.sv
// module: two-channel timer event flags and interrupt requests
`default_nettype none
module tpef_top (
  input  wire logic                                   clk,
  input  wire logic                                   rst,
  input  wire logic                                   timer_run,
  input  wire logic                                   center_align_select,
  input  wire logic                                   overflow_irq_enable,
  input  wire logic [tpef_pkg::CNT_W-1:0]             modulo,
  input  wire tpef_pkg::tpef_ch_cfg_t [tpef_pkg::NUM_CH-1:0] ch_cfg,
  input  wire logic [tpef_pkg::NUM_CH-1:0]            capture_pin,
  input  wire tpef_pkg::tpef_sw_t                     ovf_sw,
  input  wire tpef_pkg::tpef_sw_t [tpef_pkg::NUM_CH-1:0] ch_sw,
  output logic [tpef_pkg::CNT_W-1:0]                  count,
  output logic                                        overflow_flag,
  output logic [tpef_pkg::NUM_CH-1:0]                 channel_event_flag,
  output logic                                        overflow_irq,
  output logic [tpef_pkg::NUM_CH-1:0]                 channel_irq
);
  logic run_reg;
  logic cas_reg;
  logic oie_reg;
  logic ovf_event;
  logic down;

  always_ff @(posedge clk) begin
    if (rst) begin
      run_reg <= 1'b0;
      cas_reg <= 1'b0;
      oie_reg <= 1'b0;
    end else begin
      run_reg <= timer_run;
      cas_reg <= center_align_select;
      oie_reg <= overflow_irq_enable;
    end
  end

  tpef_counter u_cnt (
    .clk                 (clk),
    .rst                 (rst),
    .run                 (run_reg),
    .center_align_select (cas_reg),
    .modulo              (modulo),
    .count               (count),
    .counting_down       (down),
    .ovf_event           (ovf_event)
  );

  tpef_flag u_ovf (
    .clk         (clk),
    .rst         (rst),
    .event_pulse (ovf_event),
    .sw          (ovf_sw),
    .flag        (overflow_flag)
  );

  assign overflow_irq = overflow_flag & oie_reg;

  // edge decode for capture
  function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
    edge_hit = (sel == tpef_pkg::EDGE_RISE) ? rise :
               (sel == tpef_pkg::EDGE_FALL) ? fall :
               (sel == tpef_pkg::EDGE_ANY) ? (rise | fall) : 1'b0;
  endfunction

  genvar i;
  generate
    for (i = 0; i < tpef_pkg::NUM_CH; i++) begin : g_ch
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic match;
      logic ev;
      logic cap_ev;
      logic [1:0] sel;

      // two-stage sync, third stage for edges
      always_ff @(posedge clk) begin
        if (rst) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
        end else begin
          s1_reg <= capture_pin[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
        end
      end

      assign sel = {ch_cfg[i].edge_level_select_hi, ch_cfg[i].edge_level_select_lo};
      assign cap_ev = edge_hit(sel, s2_reg & ~s3_reg, ~s2_reg & s3_reg);
      // counter match, counted once per clock while running
      assign match = run_reg & (count == ch_cfg[i].value);
      assign ev = cas_reg ? match :
                  (ch_cfg[i].mode == tpef_pkg::TPEF_CH_CAPTURE) ? cap_ev : match;

      tpef_flag u_flag (
        .clk         (clk),
        .rst         (rst),
        .event_pulse (ev),
        .sw          (ch_sw[i]),
        .flag        (channel_event_flag[i])
      );

      assign channel_irq[i] = channel_event_flag[i] & ch_cfg[i].channel_irq_enable;
    end
  endgenerate
endmodule
`default_nettype wire

// ### test/tpef_props.sv
// checker: timing relations of flags and requests at the top ports
`default_nettype none
module tpef_props (
  input wire logic                                   clk,
  input wire logic                                   rst,
  input wire logic                                   timer_run,
  input wire logic                                   center_align_select,
  input wire logic                                   overflow_irq_enable,
  input wire logic [tpef_pkg::CNT_W-1:0]             modulo,
  input wire tpef_pkg::tpef_ch_cfg_t [tpef_pkg::NUM_CH-1:0] ch_cfg,
  input wire tpef_pkg::tpef_sw_t                     ovf_sw,
  input wire logic [tpef_pkg::CNT_W-1:0]             count,
  input wire logic                                   overflow_flag,
  input wire logic [tpef_pkg::NUM_CH-1:0]            channel_event_flag,
  input wire logic                                   overflow_irq,
  input wire logic [tpef_pkg::NUM_CH-1:0]            channel_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // clear steps only with the timer held, so no event can slip in
  sequence s_arm; !timer_run ##1 (!timer_run && ovf_sw.rd && overflow_flag); endsequence
  sequence s_wr0; !timer_run && ovf_sw.wr && !ovf_sw.wdata; endsequence
  property p_clear; s_arm ##1 s_wr0 |=> !overflow_flag; endproperty
  property p_hold; overflow_flag && !(ovf_sw.wr && !ovf_sw.wdata) |=> overflow_flag; endproperty
  property p_rst; $fell(rst) |-> !overflow_flag && channel_event_flag == 2'b00; endproperty
  property p_oirq; overflow_irq |-> overflow_flag; endproperty
  property p_cirq; (channel_irq & ~channel_event_flag) == 2'b00; endproperty
  property p_level; overflow_flag && $past(overflow_irq_enable) |-> overflow_irq; endproperty
  property p_wrap;
    !center_align_select && count == (modulo == 16'h0000 ? 16'hFFFF : modulo) ##1 count == 16'h0000
      |-> overflow_flag;
  endproperty
  property p_cmp;
    $past(timer_run) && ch_cfg[0].mode == tpef_pkg::TPEF_CH_COMPARE && count == ch_cfg[0].value
      && count != $past(count)
      |=> channel_event_flag[0];
  endproperty
  a_clear: assert property (p_clear) else $error("flag kept after clear");
  a_hold: assert property (p_hold) else $error("flag dropped");
  a_rst: assert property (p_rst) else $error("flag after reset");
  a_oirq: assert property (p_oirq) else $error("request without flag");
  a_cirq: assert property (p_cirq) else $error("channel request without flag");
  a_level: assert property (p_level) else $error("request low");
  a_wrap: assert property (p_wrap) else $error("no overflow at wrap");
  a_cmp: assert property (p_cmp) else $error("no compare flag");
endmodule
bind tpef_top tpef_props chk_u (.clk, .rst, .timer_run, .center_align_select, .overflow_irq_enable, .modulo,
  .ch_cfg, .ovf_sw, .count, .overflow_flag, .channel_event_flag, .overflow_irq, .channel_irq);
`default_nettype wire

// ### test/tpef_sw_model.sv
// model: polling software clearing the overflow flag
`default_nettype none
module tpef_sw_model (
  input  wire logic           clk,
  input  wire logic           go,
  input  wire logic           flag,
  output var tpef_pkg::tpef_sw_t sw
);
  // read while set, then write zero on the next cycle
  initial begin
    sw = '0;
    forever begin
      @(posedge clk);
      if (go && flag) begin
        #1 sw = 3'b100;
        @(posedge clk);
        #1 sw = 3'b010;
        @(posedge clk);
        #1 sw = '0;
      end
    end
  end
endmodule
`default_nettype wire

// ### test/tpef_top_tb.sv
// bench: random and corner stimulus for timer event flags
`default_nettype none
module tpef_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                         clk, rst, run, ovf_en, go, oflag, oirq, cas;
  logic [15:0]                  modulo, count;
  logic [1:0]                   pin, cflag, cirq;
  tpef_pkg::tpef_ch_cfg_t [1:0] cfg;
  tpef_pkg::tpef_sw_t           ovf_sw;
  tpef_pkg::tpef_sw_t [1:0]     ch_sw;
  int                           fail_count, checked;
  logic [31:0]                  seed;
  tpef_top dut_u (.clk(clk), .rst(rst), .timer_run(run), .center_align_select(cas), .overflow_irq_enable(ovf_en),
    .modulo(modulo), .ch_cfg(cfg), .capture_pin(pin), .ovf_sw(ovf_sw), .ch_sw(ch_sw), .count(count),
    .overflow_flag(oflag), .channel_event_flag(cflag), .overflow_irq(oirq), .channel_irq(cirq));
  tpef_sw_model sw_u (.clk(clk), .go(go), .flag(oflag), .sw(ovf_sw));
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  // capture outcome: bit 0 picks rising, bit 1 falling
  function automatic logic [15:0] cap_exp(logic [1:0] sel, logic rise);
    return 16'(rise ? sel[0] : sel[1]);
  endfunction
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one idle cycle after each strobe, so back-to-back calls never reassign in one step
  task automatic sw1(logic [2:0] v);
    ch_sw[1] = v;
    tick(1);
    ch_sw[1] = '0;
    tick(1);
  endtask
  task automatic sw0(logic [2:0] v);
    ch_sw[0] = v;
    tick(1);
    ch_sw[0] = '0;
    tick(1);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // free-running clock, 10 ns period
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // main sequence
  initial begin
    {rst, run, ovf_en, go, pin, ch_sw, fail_count, checked, seed} = {4'h8, 2'b00, 6'h00, 64'h0, 32'h0000_005A};
    cas = 1'b0;
    modulo = 16'h0010 | (rnd() & 16'h000F);
    cfg[0] = {tpef_pkg::TPEF_CH_COMPARE, 3'b001, 16'h0004 | (rnd() & 16'h0007)};
    cfg[1] = {tpef_pkg::TPEF_CH_CAPTURE, 3'b001, 16'h0000};
    tick(8);
    rst = 0;
    for (int s = 0; s < 4; s++) begin
      {cfg[1].edge_level_select_hi, cfg[1].edge_level_select_lo} = 2'(s);
      for (int r = 1; r >= 0; r--) begin
        pin[1] = r[0];
        tick(5);
        chk(16'(cflag[1]), cap_exp(2'(s), r[0]));
        chk(16'(cirq[1]), cap_exp(2'(s), r[0]));
        sw1(3'b010);
        chk(16'(cflag[1]), cap_exp(2'(s), r[0]));
        sw1(3'b101);
        sw1(3'b011);
        chk(16'(cflag[1]), cap_exp(2'(s), r[0]));
        sw1(3'b100);
        pin[1] = ~r[0];
        tick(5);
        sw1(3'b010);
        chk(16'(cflag[1]), cap_exp(2'(s), ~r[0]));
        sw1(3'b100);
        sw1(3'b010);
        chk(16'(cflag[1]), 16'h0000);
        pin[1] = r[0];
        tick(5);
        sw1(3'b100);
        sw1(3'b010);
      end
      $display("capture select %0d done", s);
    end
    run = 1;
    for (int k = 0; k < 200 && oflag !== 1'b1; k++)
      tick(1);
    chk(16'(oflag), 16'h0001);
    if (oflag !== 1'b1)
      wrap_up();
    chk(16'(oirq), 16'h0000);
    tick(20);
    chk(16'(cflag[0]), 16'h0001);
    run = 0;
    ovf_en = 1;
    tick(3);
    chk(16'(oirq), 16'h0001);
    chk(16'(cirq[0]), 16'h0001);
    go = 1;
    tick(4);
    go = 0;
    chk({oflag, oirq}, 16'h0000);
    $display("overflow and compare done");
    // centre mode: flag at reversal, then compare match while counting down
    cas = 1;
    run = 1;
    for (int k = 0; k < 200 && oflag !== 1'b1; k++)
      tick(1);
    chk(count, modulo - 16'h0001);
    run = 0;
    tick(2);
    sw0(3'b100);
    sw0(3'b010);
    chk(16'(cflag[0]), 16'h0000);
    run = 1;
    for (int k = 0; k < 200 && cflag[0] !== 1'b1; k++)
      tick(1);
    chk(count, cfg[0].value - 16'h0001);
    run = 0;
    $display("centre mode done");
    wrap_up();
  end
endmodule
`default_nettype wire
